// >>> pkg/abse_map.svh
/*
  Constants of the execution block: flag positions, flag masks, reset values,
  cycle counts and program counter steps.
  Assumes it is included by the design files that need these numbers.
*/
`ifndef ABSE_MAP_SVH
`define ABSE_MAP_SVH

// =====================================================================
// Flag register layout
`define ABSE_FL_C 0
`define ABSE_FL_Z 1
`define ABSE_FL_N 2
`define ABSE_FL_V 3
`define ABSE_FL_S 4
`define ABSE_FL_H 5
`define ABSE_FL_I 7
`define ABSE_FLAG_RST 8'h00
`define ABSE_PC_RST 16'h0000

// =====================================================================
// Flag masks, one bit per flag that an operation writes
`define ABSE_MASK_NONE 8'h00
`define ABSE_MASK_ARITH 8'h2f
`define ABSE_MASK_WORD 8'h1f
`define ABSE_MASK_LOGIC 8'h0e
`define ABSE_MASK_INVERT 8'h0f
`define ABSE_MASK_IEXIT 8'h80

// =====================================================================
// Cycle counts and program counter steps
`define ABSE_CYC_ONE 3'h1
`define ABSE_CYC_TWO 3'h2
`define ABSE_CYC_THREE 3'h3
`define ABSE_CYC_FOUR 3'h4
`define ABSE_STEP_ONE 2'h1
`define ABSE_STEP_SHORT 2'h2
`define ABSE_STEP_LONG 2'h3
`define ABSE_ONES 8'hff

`endif

// >>> pkg/abse_pkg.sv
/*
  Types of the execution block: operation codes and controller states.
  Assumes the decoder presents one of these codes with each operation.
*/
package abse_pkg;

    // =================================================================
    // Operation codes
    typedef enum logic [5:0] {
        ABSE_OP_SUM = 6'h00,
        ABSE_OP_SUM_CARRY = 6'h01,
        ABSE_OP_DIFF = 6'h02,
        ABSE_OP_DIFF_BORROW = 6'h03,
        ABSE_OP_WORD_SUM = 6'h04,
        ABSE_OP_WORD_DIFF = 6'h05,
        ABSE_OP_INTERSECT = 6'h06,
        ABSE_OP_UNION = 6'h07,
        ABSE_OP_EXCL_UNION = 6'h08,
        ABSE_OP_INVERT = 6'h09,
        ABSE_OP_TWOS = 6'h0a,
        ABSE_OP_SET_MASK = 6'h0b,
        ABSE_OP_CLEAR_MASK = 6'h0c,
        ABSE_OP_PLUS_ONE = 6'h0d,
        ABSE_OP_MINUS_ONE = 6'h0e,
        ABSE_OP_PROBE = 6'h0f,
        ABSE_OP_ZERO_REG = 6'h10,
        ABSE_OP_FILL_ONES = 6'h11,
        ABSE_OP_REL_JUMP = 6'h12,
        ABSE_OP_PTR_JUMP = 6'h13,
        ABSE_OP_REL_CALL = 6'h14,
        ABSE_OP_PTR_CALL = 6'h15,
        ABSE_OP_CALL_EXIT = 6'h16,
        ABSE_OP_INT_EXIT = 6'h17,
        ABSE_OP_CMP_SKIP_EQ = 6'h18,
        ABSE_OP_COMPARE = 6'h19,
        ABSE_OP_COMPARE_CARRY = 6'h1a,
        ABSE_OP_SKIP_REG_CLR = 6'h1b,
        ABSE_OP_SKIP_REG_ONE = 6'h1c,
        ABSE_OP_SKIP_IO_CLR = 6'h1d,
        ABSE_OP_SKIP_IO_ONE = 6'h1e,
        ABSE_OP_BRANCH_ONE = 6'h1f,
        ABSE_OP_BRANCH_ZERO = 6'h20
    } abse_op_t;

    // =================================================================
    // Controller states
    typedef enum logic [0:0] {
        ABSE_ST_IDLE = 1'b0,
        ABSE_ST_WAIT = 1'b1
    } abse_state_t;

endpackage : abse_pkg

// >>> core/abse_addsub.sv
/*
  Adder and subtractor with carry, half carry and overflow outputs.
  Assumes W is at least 4; carry reads as borrow when subtracting.
*/
`timescale 1ns/1ps
`default_nettype none

module abse_addsub #(
    parameter int W = 8
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic cin,
    input wire logic sub,
    output logic [W-1:0] sum,
    output logic carry,
    output logic half,
    output logic ovf
);
    logic [W:0] full;
    logic [4:0] nib;

    assign full = sub ? ({1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin})
                      : ({1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin});
    assign nib = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
                     : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
    assign sum = full[W-1:0];
    assign carry = full[W];
    assign half = nib[4];
    // Signed overflow: operand signs versus result sign.
    assign ovf = sub ? ((a[W-1] != b[W-1]) && (sum[W-1] != a[W-1]))
                     : ((a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]));

endmodule : abse_addsub

`default_nettype wire

// >>> core/abse_core.sv
/*
  Execution block: arithmetic, logic, jump, call, exit, compare, skip and
  branch operations with flag register and program counter.
  Assumes the decoder holds operands steady while op_valid is high and
  busy_r is low, and that the register file writes back on res_we_r.
*/
`timescale 1ns/1ps
`default_nettype none
`include "abse_map.svh"

module abse_core
    import abse_pkg::*;
#(
    parameter int PC_W = 16,
    parameter int OFS_W = 12
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire abse_op_t op,
    input wire logic use_const,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] rd_hi,
    input wire logic [7:0] rr_val,
    input wire logic [7:0] imm,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] io_val,
    input wire logic [OFS_W-1:0] rel_ofs,
    input wire logic [PC_W-1:0] z_ptr,
    input wire logic [PC_W-1:0] stack_pc,
    input wire logic next_two_word,
    output logic busy_r,
    output logic done_r,
    output logic [7:0] res_r,
    output logic [7:0] res_hi_r,
    output logic res_we_r,
    output logic res_wide_r,
    output logic [7:0] flag_r,
    output logic [PC_W-1:0] pc_r,
    output logic push_r,
    output logic [PC_W-1:0] push_pc_r,
    output logic pop_r
);
    // =================================================================
    // Operand selection
    abse_state_t state_r;
    abse_state_t state_nxt;
    logic acc;
    logic [7:0] opb;
    logic is_sub;
    logic use_cin;
    logic [7:0] a8;
    logic [7:0] b8;
    logic [7:0] ar8;
    logic ac8;
    logic ah8;
    logic av8;
    logic [15:0] ar16;
    logic ac16;
    logic av16;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] pc_rel;
    logic skip_hit;
    logic [PC_W-1:0] skip_pc;
    logic [2:0] skip_cyc;
    logic br_hit;

    assign acc = op_valid && (state_r == ABSE_ST_IDLE);
    assign opb = use_const ? imm : rr_val;
    assign is_sub = op inside {ABSE_OP_DIFF, ABSE_OP_DIFF_BORROW, ABSE_OP_COMPARE,
                               ABSE_OP_COMPARE_CARRY, ABSE_OP_TWOS, ABSE_OP_MINUS_ONE};
    assign use_cin = op inside {ABSE_OP_SUM_CARRY, ABSE_OP_DIFF_BORROW,
                                ABSE_OP_COMPARE_CARRY};
    assign a8 = (op == ABSE_OP_TWOS) ? 8'h00 : rd_val;
    assign b8 = (op == ABSE_OP_TWOS) ? rd_val :
                (op inside {ABSE_OP_PLUS_ONE, ABSE_OP_MINUS_ONE}) ? 8'h01 : opb;

    abse_addsub #(.W(8)) u_alu8 (
        .a(a8),
        .b(b8),
        .cin(use_cin & flag_r[`ABSE_FL_C]),
        .sub(is_sub),
        .sum(ar8),
        .carry(ac8),
        .half(ah8),
        .ovf(av8)
    );

    // The word constant is six bits wide; upper immediate bits are dropped.
    abse_addsub #(.W(16)) u_alu16 (
        .a({rd_hi, rd_val}),
        .b({10'h000, imm[5:0]}),
        .cin(1'b0),
        .sub(op == ABSE_OP_WORD_DIFF),
        .sum(ar16),
        .carry(ac16),
        .half(),
        .ovf(av16)
    );

    // =================================================================
    // Program counter targets
    assign pc_inc = pc_r + PC_W'(`ABSE_STEP_ONE);
    assign pc_rel = pc_r + PC_W'($signed(rel_ofs)) + PC_W'(`ABSE_STEP_ONE);
    assign skip_hit = (op == ABSE_OP_CMP_SKIP_EQ) ? (rd_val == rr_val) :
                      (op == ABSE_OP_SKIP_REG_CLR) ? !rr_val[bit_sel] :
                      (op == ABSE_OP_SKIP_REG_ONE) ? rr_val[bit_sel] :
                      (op == ABSE_OP_SKIP_IO_CLR) ? !io_val[bit_sel] :
                      (op == ABSE_OP_SKIP_IO_ONE) ? io_val[bit_sel] : 1'b0;
    assign skip_pc = !skip_hit ? pc_inc :
                     next_two_word ? pc_r + PC_W'(`ABSE_STEP_LONG) :
                     pc_r + PC_W'(`ABSE_STEP_SHORT);
    assign skip_cyc = !skip_hit ? `ABSE_CYC_ONE :
                      next_two_word ? `ABSE_CYC_THREE : `ABSE_CYC_TWO;
    assign br_hit = (op == ABSE_OP_BRANCH_ONE) ? flag_r[bit_sel] :
                    (op == ABSE_OP_BRANCH_ZERO) ? !flag_r[bit_sel] : 1'b0;

    // =================================================================
    // Per-operation result, flags, target and cycle count
    logic [7:0] f_res;
    logic [7:0] f_hi;
    logic f_we;
    logic f_wide;
    logic [7:0] f_mask;
    logic f_c;
    logic f_h;
    logic f_v;
    logic f_z;
    logic f_n;
    logic [7:0] f_flags;
    logic [PC_W-1:0] f_pc;
    logic [2:0] f_cyc;
    logic f_push;
    logic f_pop;

    always_comb begin
        f_res = ar8;
        f_hi = 8'h00;
        f_we = 1'b1;
        f_wide = 1'b0;
        f_mask = `ABSE_MASK_ARITH;
        f_c = ac8;
        f_h = ah8;
        f_v = av8;
        f_pc = pc_inc;
        f_cyc = `ABSE_CYC_ONE;
        f_push = 1'b0;
        f_pop = 1'b0;
        case (op)
            ABSE_OP_WORD_SUM, ABSE_OP_WORD_DIFF: begin
                f_res = ar16[7:0];
                f_hi = ar16[15:8];
                f_wide = 1'b1;
                f_mask = `ABSE_MASK_WORD;
                f_c = ac16;
                f_v = av16;
                f_cyc = `ABSE_CYC_TWO;
            end
            ABSE_OP_INTERSECT, ABSE_OP_PROBE: begin
                f_res = rd_val & ((op == ABSE_OP_PROBE) ? rd_val : opb);
                f_mask = `ABSE_MASK_LOGIC;
                f_v = 1'b0;
            end
            ABSE_OP_UNION, ABSE_OP_SET_MASK: begin
                // The mask form always takes the constant, whatever use_const says.
                f_res = rd_val | ((op == ABSE_OP_SET_MASK) ? imm : opb);
                f_mask = `ABSE_MASK_LOGIC;
                f_v = 1'b0;
            end
            ABSE_OP_EXCL_UNION, ABSE_OP_ZERO_REG: begin
                f_res = rd_val ^ ((op == ABSE_OP_ZERO_REG) ? rd_val : opb);
                f_mask = `ABSE_MASK_LOGIC;
                f_v = 1'b0;
            end
            ABSE_OP_CLEAR_MASK: begin
                f_res = rd_val & (`ABSE_ONES - imm);
                f_mask = `ABSE_MASK_LOGIC;
                f_v = 1'b0;
            end
            ABSE_OP_INVERT: begin
                f_res = `ABSE_ONES - rd_val;
                f_mask = `ABSE_MASK_INVERT;
                f_c = 1'b1;
                f_v = 1'b0;
            end
            ABSE_OP_PLUS_ONE, ABSE_OP_MINUS_ONE: begin
                f_mask = `ABSE_MASK_LOGIC;
            end
            ABSE_OP_FILL_ONES: begin
                f_res = `ABSE_ONES;
                f_mask = `ABSE_MASK_NONE;
            end
            ABSE_OP_COMPARE, ABSE_OP_COMPARE_CARRY: begin
                f_we = 1'b0;
            end
            ABSE_OP_REL_JUMP, ABSE_OP_REL_CALL: begin
                f_we = 1'b0;
                f_mask = `ABSE_MASK_NONE;
                f_pc = pc_rel;
                f_push = (op == ABSE_OP_REL_CALL);
                f_cyc = f_push ? `ABSE_CYC_THREE : `ABSE_CYC_TWO;
            end
            ABSE_OP_PTR_JUMP, ABSE_OP_PTR_CALL: begin
                f_we = 1'b0;
                f_mask = `ABSE_MASK_NONE;
                f_pc = z_ptr;
                f_push = (op == ABSE_OP_PTR_CALL);
                f_cyc = f_push ? `ABSE_CYC_THREE : `ABSE_CYC_TWO;
            end
            ABSE_OP_CALL_EXIT, ABSE_OP_INT_EXIT: begin
                f_we = 1'b0;
                f_mask = (op == ABSE_OP_INT_EXIT) ? `ABSE_MASK_IEXIT : `ABSE_MASK_NONE;
                f_pc = stack_pc;
                f_pop = 1'b1;
                f_cyc = `ABSE_CYC_FOUR;
            end
            ABSE_OP_CMP_SKIP_EQ, ABSE_OP_SKIP_REG_CLR, ABSE_OP_SKIP_REG_ONE,
            ABSE_OP_SKIP_IO_CLR, ABSE_OP_SKIP_IO_ONE: begin
                f_we = 1'b0;
                f_mask = `ABSE_MASK_NONE;
                f_pc = skip_pc;
                f_cyc = skip_cyc;
            end
            ABSE_OP_BRANCH_ONE, ABSE_OP_BRANCH_ZERO: begin
                f_we = 1'b0;
                f_mask = `ABSE_MASK_NONE;
                f_pc = br_hit ? pc_rel : pc_inc;
                f_cyc = br_hit ? `ABSE_CYC_TWO : `ABSE_CYC_ONE;
            end
            default: begin
            end
        endcase
        f_z = f_wide ? ({f_hi, f_res} == 16'h0000) : (f_res == 8'h00);
        f_n = f_wide ? f_hi[7] : f_res[7];
        // Only masked flags change; the rest hold their old value.
        f_flags = (flag_r & ~f_mask)
                | ({1'b1, 1'b0, f_h, f_n ^ f_v, f_v, f_n, f_z, f_c} & f_mask);
    end

    // =================================================================
    // Controller: multi-cycle results wait in pending flops until the last cycle
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [7:0] p_res_r;
    logic [7:0] p_hi_r;
    logic p_we_r;
    logic p_wide_r;
    logic [7:0] p_flags_r;
    logic [PC_W-1:0] p_pc_r;
    logic p_push_r;
    logic p_pop_r;
    logic commit;
    logic from_p;

    assign from_p = (state_r == ABSE_ST_WAIT);
    assign commit = (acc && f_cyc == `ABSE_CYC_ONE) || (from_p && cnt_r == `ABSE_CYC_ONE);
    assign state_nxt = (acc && f_cyc != `ABSE_CYC_ONE) ? ABSE_ST_WAIT :
                       (from_p && cnt_r == `ABSE_CYC_ONE) ? ABSE_ST_IDLE : state_r;
    assign cnt_nxt = acc ? f_cyc - 3'h1 : from_p ? cnt_r - 3'h1 : cnt_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ABSE_ST_IDLE;
            cnt_r <= 3'h0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= (state_nxt == ABSE_ST_WAIT);
        end
    end

    always_ff @(posedge core_clk) begin
        if (acc) begin
            p_res_r <= f_res;
            p_hi_r <= f_hi;
            p_we_r <= f_we;
            p_wide_r <= f_wide;
            p_flags_r <= f_flags;
            p_pc_r <= f_pc;
            p_push_r <= f_push;
            p_pop_r <= f_pop;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_r <= 1'b0;
            res_r <= 8'h00;
            res_hi_r <= 8'h00;
            res_we_r <= 1'b0;
            res_wide_r <= 1'b0;
            flag_r <= `ABSE_FLAG_RST;
            pc_r <= PC_W'(`ABSE_PC_RST);
            push_r <= 1'b0;
            push_pc_r <= PC_W'(`ABSE_PC_RST);
            pop_r <= 1'b0;
        end else begin
            done_r <= commit;
            res_we_r <= commit && (from_p ? p_we_r : f_we);
            push_r <= commit && (from_p ? p_push_r : f_push);
            pop_r <= commit && (from_p ? p_pop_r : f_pop);
            if (commit) begin
                res_r <= from_p ? p_res_r : f_res;
                res_hi_r <= from_p ? p_hi_r : f_hi;
                res_wide_r <= from_p ? p_wide_r : f_wide;
                flag_r <= from_p ? p_flags_r : f_flags;
                pc_r <= from_p ? p_pc_r : f_pc;
                push_pc_r <= pc_r + PC_W'(`ABSE_STEP_ONE);
            end
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_take(abse_op_t o);
        acc && op == o;
    endsequence
    sequence s_done_at2;
        !done_r ##1 done_r;
    endsequence
    sequence s_done_at3;
        !done_r [*2] ##1 done_r;
    endsequence

    a_sum_result: assert property (s_take(ABSE_OP_SUM) |=> done_r && res_we_r
        && res_r == $past(rd_val) + $past(opb)) else $error("sum result wrong");
    a_diff_borrow: assert property (s_take(ABSE_OP_DIFF_BORROW) |=> res_r ==
        $past(rd_val) - $past(opb) - {7'h00, $past(flag_r[0])}) else $error("borrow diff wrong");
    a_word_time: assert property (s_take(ABSE_OP_WORD_SUM) |=> s_done_at2)
        else $error("word sum not two cycles");
    a_word_diff: assert property (s_take(ABSE_OP_WORD_DIFF) |-> ##2
        {res_hi_r, res_r} == $past({rd_hi, rd_val}, 2) - {10'h000, $past(imm[5:0], 2)})
        else $error("word difference wrong");
    a_logic_flags: assert property (s_take(ABSE_OP_INTERSECT) |=> !flag_r[3]
        && flag_r[0] == $past(flag_r[0]) && flag_r[5] == $past(flag_r[5]))
        else $error("logic flags wrong");
    a_invert_carry: assert property (s_take(ABSE_OP_INVERT) |=> flag_r[0]
        && res_r == ~$past(rd_val)) else $error("invert wrong");
    a_neg_value: assert property (s_take(ABSE_OP_TWOS) |=> res_r == 8'h00 - $past(rd_val))
        else $error("twos invert wrong");
    a_inc_keeps_c: assert property (s_take(ABSE_OP_PLUS_ONE) |=>
        flag_r[0] == $past(flag_r[0])) else $error("plus one touched carry");
    a_fill_flags: assert property (s_take(ABSE_OP_FILL_ONES) |=>
        flag_r == $past(flag_r) && res_r == 8'hff) else $error("fill ones wrong");
    a_call_time: assert property (s_take(ABSE_OP_REL_CALL) |=> s_done_at3
        ##0 push_r) else $error("relative call timing wrong");
    a_ptr_jump: assert property (s_take(ABSE_OP_PTR_JUMP) |-> ##2
        pc_r == $past(z_ptr, 2)) else $error("pointer jump target wrong");
    a_exit_ibit: assert property (s_take(ABSE_OP_INT_EXIT) |-> ##4
        done_r && pop_r && flag_r[7]) else $error("interrupt exit wrong");
    a_cmp_nowrite: assert property (s_take(ABSE_OP_COMPARE) |=>
        done_r && !res_we_r) else $error("compare wrote register");
    a_skip_short: assert property (acc && op == ABSE_OP_SKIP_REG_ONE
        && rr_val[bit_sel] && !next_two_word |=> s_done_at2)
        else $error("short skip timing wrong");
    a_branch_taken: assert property (acc && op == ABSE_OP_BRANCH_ZERO
        && !flag_r[bit_sel] |-> ##2 done_r && pc_r == $past(pc_rel, 2))
        else $error("branch target wrong");

endmodule : abse_core

`default_nettype wire

// >>> tb/abse_stack.sv
/*
  Return stack model standing where the core's stack sits.
  Assumes pushes and pops arrive as one-cycle pulses from the execution block.
*/
`timescale 1ns/1ps
`default_nettype none

module abse_stack (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic push_r,
    input wire logic [15:0] push_pc_r,
    input wire logic pop_r,
    output logic [15:0] stack_pc
);
    // =================================================================
    // Storage
    logic [15:0] mem_r [0:7];
    logic [2:0] sp_r;
    logic [15:0] idle_r;

    // An empty stack shows a changing pattern, so a stale address never passes.
    assign stack_pc = (sp_r == 3'h0) ? idle_r : mem_r[sp_r - 3'h1];
    always_ff @(posedge core_clk) begin
        idle_r <= rst ? 16'h5a5a : ~idle_r;
        if (rst) begin
            sp_r <= 3'h0;
        end else if (push_r) begin
            mem_r[sp_r] <= push_pc_r;
            sp_r <= sp_r + 3'h1;
        end else if (pop_r) begin
            sp_r <= sp_r - 3'h1;
        end
    end
endmodule : abse_stack
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench of the execution block with a return stack model.
  Assumes inputs are driven at the falling edge and results settle by then.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
    import abse_pkg::*;
();
    // =================================================================
    // Signals
    logic core_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, use_const = 1'b0, next_two_word = 1'b0;
    abse_op_t op = ABSE_OP_SUM;
    logic [7:0] rd_val = 8'h00, rd_hi = 8'h00, rr_val = 8'h00, imm = 8'h00, io_val = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [11:0] rel_ofs = 12'h000;
    logic [15:0] z_ptr = 16'h0000, stack_pc, pc_r, push_pc_r, pc0;
    logic busy_r, done_r, res_we_r, res_wide_r, push_r, pop_r;
    logic [7:0] res_r, res_hi_r, flag_r;
    int miscompares = 0, checks_done = 0, n;

    always #12.5 core_clk = ~core_clk;

    abse_core dut_u (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op(op),
        .use_const(use_const), .rd_val(rd_val), .rd_hi(rd_hi), .rr_val(rr_val), .imm(imm),
        .bit_sel(bit_sel), .io_val(io_val), .rel_ofs(rel_ofs), .z_ptr(z_ptr),
        .stack_pc(stack_pc), .next_two_word(next_two_word), .busy_r(busy_r), .done_r(done_r),
        .res_r(res_r), .res_hi_r(res_hi_r), .res_we_r(res_we_r), .res_wide_r(res_wide_r),
        .flag_r(flag_r), .pc_r(pc_r), .push_r(push_r), .push_pc_r(push_pc_r), .pop_r(pop_r));
    abse_stack stk_u (.core_clk(core_clk), .rst(rst), .push_r(push_r), .push_pc_r(push_pc_r),
        .pop_r(pop_r), .stack_pc(stack_pc));

    // =================================================================
    // Shared tasks
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Presents one operation, waits for its completion and checks the cycle count.
    task run(input abse_op_t o, input int cyc);
        @(negedge core_clk);
        op = o;
        op_valid = 1'b1;
        pc0 = pc_r;
        @(negedge core_clk);
        op_valid = 1'b0;
        chk("busy", 16'(busy_r), 16'(cyc > 1));
        n = 1;
        while (done_r !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        chk("cycles", 16'(n), 16'(cyc));
    endtask : run

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // =================================================================
    // Scenarios
    task t_arith;
        rd_val = 8'hff; rr_val = 8'h01;
        run(ABSE_OP_SUM, 1);
        chk("sum", {res_we_r, res_r}, 16'h0100);
        chk("sum flags", flag_r, 8'h23);
        rd_val = 8'h01;
        run(ABSE_OP_SUM_CARRY, 1);
        chk("sum carry", {res_r, flag_r}, 16'h0300);
        rd_val = 8'h00;
        run(ABSE_OP_DIFF, 1);
        chk("diff", {res_r, flag_r}, 16'hff25);
        rd_val = 8'h80; use_const = 1'b1; imm = 8'h00;
        run(ABSE_OP_DIFF_BORROW, 1);
        chk("const borrow", {res_r, flag_r}, 16'h7f28);
        $display("arith done");
    endtask : t_arith

    task t_word;
        rd_hi = 8'hff; rd_val = 8'hff; imm = 8'h01;
        run(ABSE_OP_WORD_SUM, 2);
        chk("word sum", {res_hi_r, res_r}, 16'h0000);
        chk("word sum flags", {res_wide_r, flag_r}, 16'h0123);
        rd_hi = 8'h80; rd_val = 8'h00;
        run(ABSE_OP_WORD_DIFF, 2);
        chk("word diff", {res_hi_r, res_r}, 16'h7fff);
        chk("word diff flags", flag_r, 8'h38);
        $display("word done");
    endtask : t_word

    task t_logic;
        abse_op_t ops[12] = '{ABSE_OP_INTERSECT, ABSE_OP_UNION, ABSE_OP_EXCL_UNION,
            ABSE_OP_SET_MASK, ABSE_OP_CLEAR_MASK, ABSE_OP_INVERT, ABSE_OP_TWOS,
            ABSE_OP_PLUS_ONE, ABSE_OP_MINUS_ONE, ABSE_OP_PROBE, ABSE_OP_ZERO_REG,
            ABSE_OP_FILL_ONES};
        logic [7:0] rs[12] = '{8'h30, 8'hfc, 8'hcc, 8'hfc, 8'hc0, 8'h0f, 8'h10, 8'hf1,
            8'hef, 8'hf0, 8'h00, 8'hff};
        logic [7:0] fl[12] = '{8'h30, 8'h34, 8'h34, 8'h34, 8'h34, 8'h31, 8'h11, 8'h15,
            8'h15, 8'h15, 8'h13, 8'h13};
        rd_val = 8'hf0; rr_val = 8'h3c; imm = 8'h3c;
        for (int i = 0; i < 12; i++) begin
            use_const = i[0];
            run(ops[i], 1);
            chk(ops[i].name(), {res_r, flag_r}, {rs[i], fl[i]});
        end
        $display("logic done");
    endtask : t_logic

    task t_compare;
        rd_val = 8'h10; rr_val = 8'h10; use_const = 1'b0;
        run(ABSE_OP_COMPARE, 1);
        chk("cmp", {res_we_r, flag_r}, 16'h0012);
        use_const = 1'b1; imm = 8'h20;
        run(ABSE_OP_COMPARE, 1);
        chk("cmp const", {res_we_r, flag_r}, 16'h0015);
        use_const = 1'b0; rr_val = 8'h0f;
        run(ABSE_OP_COMPARE_CARRY, 1);
        chk("cmp carry", {res_we_r, flag_r}, 16'h0032);
        $display("compare done");
    endtask : t_compare

    task t_flow;
        rel_ofs = 12'hffe;
        run(ABSE_OP_REL_JUMP, 2);
        chk("rel jump", pc_r, pc0 + 16'hffff);
        z_ptr = 16'h1234;
        run(ABSE_OP_PTR_JUMP, 2);
        chk("ptr jump", pc_r, 16'h1234);
        rel_ofs = 12'h010;
        run(ABSE_OP_REL_CALL, 3);
        chk("rel call", pc_r, 16'h1245);
        chk("rel call push", {push_r, pop_r}, 16'h0002);
        z_ptr = 16'h0400;
        run(ABSE_OP_PTR_CALL, 3);
        chk("ptr call", {pc_r[7:0], flag_r}, 16'h0032);
        run(ABSE_OP_CALL_EXIT, 4);
        chk("call exit", pc_r, 16'h1246);
        chk("call exit pop", {push_r, pop_r}, 16'h0001);
        run(ABSE_OP_INT_EXIT, 4);
        chk("int exit", {pc_r[7:0], flag_r}, 16'h35b2);
        $display("flow done");
    endtask : t_flow

    task t_skip;
        abse_op_t ops[9] = '{ABSE_OP_CMP_SKIP_EQ, ABSE_OP_CMP_SKIP_EQ, ABSE_OP_CMP_SKIP_EQ,
            ABSE_OP_SKIP_REG_CLR, ABSE_OP_SKIP_REG_CLR, ABSE_OP_SKIP_REG_ONE,
            ABSE_OP_SKIP_IO_CLR, ABSE_OP_SKIP_IO_ONE, ABSE_OP_SKIP_IO_ONE};
        logic [7:0] rr[9] = '{8'h55, 8'h55, 8'h54, 8'hf7, 8'h08, 8'h08, 8'h55, 8'h55, 8'h55};
        logic [7:0] io[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h7f, 8'h80};
        int cy[9] = '{2, 3, 1, 2, 1, 2, 2, 1, 3};
        rd_val = 8'h55; bit_sel = 3'h3;
        for (int i = 0; i < 9; i++) begin
            rr_val = rr[i];
            io_val = io[i];
            next_two_word = (cy[i] == 3);
            if (i > 5) bit_sel = 3'h7;
            run(ops[i], cy[i]);
            chk(ops[i].name(), {pc_r[7:0], flag_r}, {8'(pc0 + 16'(cy[i])), 8'hb2});
        end
        $display("skip done");
    endtask : t_skip

    task t_branch;
        bit_sel = 3'h7; rel_ofs = 12'h005;
        run(ABSE_OP_BRANCH_ONE, 2);
        chk("branch one", pc_r, pc0 + 16'h0006);
        run(ABSE_OP_BRANCH_ZERO, 1);
        chk("branch zero idle", pc_r, pc0 + 16'h0001);
        bit_sel = 3'h6; rel_ofs = 12'hffc;
        run(ABSE_OP_BRANCH_ZERO, 2);
        chk("branch zero", pc_r, pc0 + 16'hfffd);
        run(ABSE_OP_BRANCH_ONE, 1);
        chk("branch one idle", {pc_r[7:0], flag_r}, {8'(pc0 + 16'h0001), 8'hb2});
        $display("branch done");
    endtask : t_branch

    // =================================================================
    // Sequence and watchdog
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        t_arith();
        t_word();
        t_logic();
        t_compare();
        t_flow();
        t_skip();
        t_branch();
        close_out();
    end

    initial begin
        #(25 * 2000);
        miscompares++;
        close_out();
    end
endmodule : tb
`default_nettype wire
